// >>> pfi_credit_adj.sv
// Shared constants and the credit adjuster for update-flow-control messages.
// Assumes one core clock, synchronous active-high reset and a clock enable.

//--------------------------------------------------------------
// Package
//--------------------------------------------------------------
package pfi_pkg;
	// Register byte offsets on the APB
	localparam logic [11:0] PFI_CTRL_OFFSET   = 12'h000;
	localparam logic [11:0] PFI_STATUS_OFFSET = 12'h004;
	localparam logic [11:0] PFI_COUNT_OFFSET  = 12'h008;

	// Control word field positions
	localparam int PFI_RXDLLP_LSB = 15;
	localparam int PFI_REPLAY_BIT = 17;
	localparam int PFI_ACKNAK_LSB = 18;
	localparam int PFI_ECRC_BIT   = 20;
	localparam int PFI_LCRC_BIT   = 21;
	localparam int PFI_TXDLLP_LSB = 22;
	localparam int PFI_UFC_LSB    = 24;
	localparam int PFI_VCSEL_LSB  = 29;

	// Reset values and field masks
	localparam logic [31:0] PFI_CTRL_RESET   = 32'h0000_0000;
	localparam logic [31:0] PFI_CTRL_MASK    = 32'hFFFF_8000;
	localparam logic [31:0] PFI_X8_MASK      = 32'h0010_0000;
	localparam logic [15:0] PFI_COUNT_RESET  = 16'h0000;
	localparam logic [4:0]  PFI_STICKY_RESET = 5'h00;

	// DLLP class codes on the link-layer ports
	localparam logic [1:0] PFI_DLLP_ACKNAK = 2'h1;
	localparam logic [1:0] PFI_DLLP_PM     = 2'h2;
	localparam logic [1:0] PFI_DLLP_FC     = 2'h3;

	// Credit type codes on the update-flow-control ports
	localparam logic [1:0] PFI_UFC_NONE = 2'h0;
	localparam logic [1:0] PFI_POSTED    = 2'h1;
	localparam logic [1:0] PFI_NONPOSTED = 2'h2;
	localparam logic [1:0] PFI_CMPL      = 2'h3;

	// Credit step codes: none, plus one, minus one
	localparam logic [1:0] PFI_STEP_NONE = 2'h0;
	localparam logic [1:0] PFI_STEP_INC  = 2'h1;
	localparam logic [1:0] PFI_STEP_DEC  = 2'h3;

	// ACK substitution modes
	localparam logic [1:0] PFI_ACK_NORMAL = 2'h0;
	localparam logic [1:0] PFI_ACK_SAME   = 2'h1;
	localparam logic [1:0] PFI_ACK_INC    = 2'h2;
	localparam logic [1:0] PFI_ACK_DEC    = 2'h3;

	localparam int PFI_SEQ_W     = 12;
	localparam int PFI_HDR_W     = 8;
	localparam int PFI_DATA_W    = 12;
	localparam int PFI_DBG_SLICE = 125;

	// Credit fault code to {type, header step, data step}
	function automatic logic [5:0] pfi_ufc_decode(input logic [4:0] code);
		logic [5:0] d;
		d = {PFI_UFC_NONE, PFI_STEP_NONE, PFI_STEP_NONE};
		case (code)
			5'h01: d = {PFI_POSTED, PFI_STEP_INC, PFI_STEP_NONE};
			5'h02: d = {PFI_POSTED, PFI_STEP_NONE, PFI_STEP_INC};
			5'h03: d = {PFI_POSTED, PFI_STEP_INC, PFI_STEP_INC};
			5'h04: d = {PFI_NONPOSTED, PFI_STEP_INC, PFI_STEP_NONE};
			5'h05: d = {PFI_NONPOSTED, PFI_STEP_NONE, PFI_STEP_INC};
			5'h06: d = {PFI_NONPOSTED, PFI_STEP_INC, PFI_STEP_INC};
			5'h07: d = {PFI_CMPL, PFI_STEP_INC, PFI_STEP_NONE};
			5'h08: d = {PFI_CMPL, PFI_STEP_NONE, PFI_STEP_INC};
			5'h09: d = {PFI_CMPL, PFI_STEP_INC, PFI_STEP_INC};
			5'h0A: d = {PFI_POSTED, PFI_STEP_DEC, PFI_STEP_NONE};
			5'h0B: d = {PFI_POSTED, PFI_STEP_NONE, PFI_STEP_DEC};
			5'h0C: d = {PFI_POSTED, PFI_STEP_DEC, PFI_STEP_DEC};
			5'h0D: d = {PFI_NONPOSTED, PFI_STEP_DEC, PFI_STEP_NONE};
			5'h0E: d = {PFI_NONPOSTED, PFI_STEP_NONE, PFI_STEP_DEC};
			5'h0F: d = {PFI_NONPOSTED, PFI_STEP_DEC, PFI_STEP_DEC};
			5'h10: d = {PFI_CMPL, PFI_STEP_DEC, PFI_STEP_NONE};
			5'h11: d = {PFI_CMPL, PFI_STEP_NONE, PFI_STEP_DEC};
			5'h12: d = {PFI_CMPL, PFI_STEP_DEC, PFI_STEP_DEC};
			5'h13: d = {PFI_POSTED, PFI_STEP_INC, PFI_STEP_DEC};
			5'h14: d = {PFI_POSTED, PFI_STEP_DEC, PFI_STEP_INC};
			5'h15: d = {PFI_NONPOSTED, PFI_STEP_INC, PFI_STEP_DEC};
			5'h16: d = {PFI_NONPOSTED, PFI_STEP_DEC, PFI_STEP_INC};
			5'h17: d = {PFI_CMPL, PFI_STEP_INC, PFI_STEP_DEC};
			5'h18: d = {PFI_CMPL, PFI_STEP_DEC, PFI_STEP_INC};
			default: d = {PFI_UFC_NONE, PFI_STEP_NONE, PFI_STEP_NONE};
		endcase
		return d;
	endfunction : pfi_ufc_decode

	// Modulo step of a credit or sequence value
	function automatic logic [11:0] pfi_step(input logic [11:0] v, input logic [1:0] s);
		logic [11:0] r;
		r = v;
		if (s == PFI_STEP_INC) begin
			r = v + 12'h001;
		end else if (s == PFI_STEP_DEC) begin
			r = v - 12'h001;
		end
		return r;
	endfunction : pfi_step
endpackage : pfi_pkg

`timescale 1ns/10ps
`default_nettype none

//--------------------------------------------------------------
// Credit adjuster
//--------------------------------------------------------------
module pfi_credit_adj import pfi_pkg::*; (
	input  wire logic                  mclk,
	input  wire logic                  srst,
	input  wire logic                  ce,
	input  wire logic [4:0]            fault_code,
	input  wire logic                  ufc_valid,
	input  wire logic [1:0]            ufc_type,
	input  wire logic [PFI_HDR_W-1:0]  ufc_hdr,
	input  wire logic [PFI_DATA_W-1:0] ufc_data,
	output logic                       ufc_out_valid,
	output logic [PFI_HDR_W-1:0]       ufc_out_hdr,
	output logic [PFI_DATA_W-1:0]      ufc_out_data,
	output logic                       ufc_hit
);
	logic [5:0]  dec;
	logic        match;
	logic [11:0] hdr_wide;

	assign dec      = pfi_ufc_decode(fault_code);
	assign match    = ufc_valid && (dec[5:4] != PFI_UFC_NONE) && (dec[5:4] == ufc_type);
	assign hdr_wide = pfi_step({4'h0, ufc_hdr}, match ? dec[3:2] : PFI_STEP_NONE);

	// Message goes through one register stage, adjusted or not
	always_ff @(posedge mclk) begin
		if (srst) begin
			ufc_out_valid <= 1'b0;
			ufc_out_hdr   <= '0;
			ufc_out_data  <= '0;
			ufc_hit       <= 1'b0;
		end else if (ce) begin
			ufc_out_valid <= ufc_valid;
			ufc_out_hdr   <= hdr_wide[PFI_HDR_W-1:0];
			ufc_out_data  <= pfi_step(ufc_data, match ? dec[1:0] : PFI_STEP_NONE);
			ufc_hit       <= match;
		end
	end
endmodule : pfi_credit_adj

`default_nettype wire

// >>> pfi_ctrl.sv
// Fault-injection control for the link and transaction layers, set over APB.
// Assumes the link layer offers event strobes on the core clock mclk.
//
// The APB interface to the registers and the address map are this design's own decisions.

`timescale 1ns/10ps
`default_nettype none

module pfi_ctrl import pfi_pkg::*; #(
	parameter bit IS_X8  = 1'b0,
	parameter int NUM_VC = 4
) (
	input  wire logic                            mclk,
	input  wire logic                            srst,
	input  wire logic                            ce,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [11:0]                     paddr,
	input  wire logic [31:0]                     pwdata,
	output logic [31:0]                          prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	input  wire logic                            rx_dllp_valid,
	input  wire logic [1:0]                      rx_dllp_class,
	output logic                                 rx_dllp_crc_force,
	output logic                                 force_replay,
	input  wire logic                            ack_in_valid,
	input  wire logic [PFI_SEQ_W-1:0]            ack_in_seq,
	output logic                                 ack_out_valid,
	output logic                                 ack_out_nak,
	output logic [PFI_SEQ_W-1:0]                 ack_out_seq,
	output logic                                 tx_ecrc_corrupt,
	output logic                                 tx_lcrc_corrupt,
	input  wire logic                            tx_dllp_valid,
	input  wire logic [1:0]                      tx_dllp_class,
	output logic                                 tx_dllp_crc_corrupt,
	input  wire logic                            ufc_valid,
	input  wire logic [1:0]                      ufc_type,
	input  wire logic [PFI_HDR_W-1:0]            ufc_hdr,
	input  wire logic [PFI_DATA_W-1:0]           ufc_data,
	output logic                                 ufc_out_valid,
	output logic [PFI_HDR_W-1:0]                 ufc_out_hdr,
	output logic [PFI_DATA_W-1:0]                ufc_out_data,
	input  wire logic [NUM_VC*PFI_DBG_SLICE-1:0] vc_debug,
	output logic [PFI_DBG_SLICE-1:0]             dbg_slice
);
	//--------------------------------------------------------------
	// Declarations
	//--------------------------------------------------------------
	logic [31:0] ctrl;
	logic [31:0] next_ctrl;
	logic [31:0] ctrl_keep;
	logic [4:0]  sticky;
	logic [4:0]  next_sticky;
	logic [4:0]  hit_vec;
	logic [15:0] inject_count;
	logic        rx_armed;
	logic        rd_fresh;
	logic        acc;
	logic        wr_en;
	logic        rd_en;
	logic        sel_ctrl;
	logic        sel_status;
	logic        sel_count;
	logic        rx_hit;
	logic        ack_hit;
	logic        tx_hit;
	logic        ufc_hit;
	logic [1:0]  rx_field;
	logic [1:0]  ack_field;
	logic [1:0]  tx_field;
	logic [1:0]  tx_class_sel;

	// Fields that this build keeps; the eight-lane build keeps only the ECRC bit
	assign ctrl_keep = IS_X8 ? PFI_X8_MASK : PFI_CTRL_MASK;

	//--------------------------------------------------------------
	// APB slave
	//--------------------------------------------------------------
	// Zero wait states; a read whose setup edge was frozen waits one edge for its data
	assign pready     = ce && (pwrite || rd_fresh);
	assign acc        = psel && penable && pready;
	assign wr_en      = acc && pwrite;
	assign rd_en      = acc && !pwrite;
	assign sel_ctrl   = (paddr == PFI_CTRL_OFFSET);
	assign sel_status = (paddr == PFI_STATUS_OFFSET);
	assign sel_count  = (paddr == PFI_COUNT_OFFSET);

	always_comb begin
		pslverr = 1'b0;
		if (psel && penable) begin
			pslverr = !(sel_ctrl || sel_status || sel_count);
		end
	end

	// Marks that read data for the open transfer is loaded
	always_ff @(posedge mclk) begin
		if (srst) begin
			rd_fresh <= 1'b0;
		end else if (ce) begin
			if (acc) begin
				rd_fresh <= 1'b0;
			end else if (psel && !pwrite) begin
				rd_fresh <= 1'b1;
			end
		end
	end

	// Read data comes from a register, loaded at the first live edge of a read
	always_ff @(posedge mclk) begin
		if (srst) begin
			prdata <= '0;
		end else if (ce) begin
			if (psel && !pwrite && !rd_fresh) begin
				if (sel_ctrl) begin
					prdata <= ctrl;
				end else if (sel_status) begin
					prdata <= {26'h0, rx_armed, sticky};
				end else if (sel_count) begin
					prdata <= {16'h0, inject_count};
				end else begin
					prdata <= '0;
				end
			end
		end
	end

	//--------------------------------------------------------------
	// Control register
	//--------------------------------------------------------------
	// Reserved and eight-lane-reserved bits never store, so they read zero
	always_comb begin
		next_ctrl = ctrl;
		if (wr_en && sel_ctrl) begin
			next_ctrl = pwdata & ctrl_keep;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl <= PFI_CTRL_RESET;
		end else if (ce) begin
			ctrl <= next_ctrl;
		end
	end

	assign rx_field  = ctrl[PFI_RXDLLP_LSB +: 2];
	assign ack_field = ctrl[PFI_ACKNAK_LSB +: 2];
	assign tx_field  = ctrl[PFI_TXDLLP_LSB +: 2];

	//--------------------------------------------------------------
	// Received DLLP fault
	//--------------------------------------------------------------
	// One shot: armed by a write of a nonzero class, spent by the first match
	assign rx_hit = rx_armed && rx_dllp_valid && (rx_dllp_class == rx_field);

	always_ff @(posedge mclk) begin
		if (srst) begin
			rx_armed <= 1'b0;
		end else if (ce) begin
			if (wr_en && sel_ctrl) begin
				rx_armed <= (next_ctrl[PFI_RXDLLP_LSB +: 2] != 2'h0);
			end else if (rx_hit) begin
				rx_armed <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			rx_dllp_crc_force <= 1'b0;
		end else if (ce) begin
			rx_dllp_crc_force <= rx_hit;
		end
	end

	//--------------------------------------------------------------
	// Level faults: replay, ECRC, LCRC
	//--------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			force_replay    <= 1'b0;
			tx_ecrc_corrupt <= 1'b0;
			tx_lcrc_corrupt <= 1'b0;
		end else if (ce) begin
			force_replay    <= ctrl[PFI_REPLAY_BIT];
			tx_ecrc_corrupt <= ctrl[PFI_ECRC_BIT];
			tx_lcrc_corrupt <= ctrl[PFI_LCRC_BIT];
		end
	end

	//--------------------------------------------------------------
	// ACK substitution
	//--------------------------------------------------------------
	assign ack_hit = ack_in_valid && (ack_field != PFI_ACK_NORMAL);

	always_ff @(posedge mclk) begin
		if (srst) begin
			ack_out_valid <= 1'b0;
			ack_out_nak   <= 1'b0;
			ack_out_seq   <= '0;
		end else if (ce) begin
			ack_out_valid <= ack_in_valid;
			ack_out_nak   <= ack_hit;
			case (ack_field)
				PFI_ACK_INC: ack_out_seq <= pfi_step(ack_in_seq, PFI_STEP_INC);
				PFI_ACK_DEC: ack_out_seq <= pfi_step(ack_in_seq, PFI_STEP_DEC);
				default:     ack_out_seq <= ack_in_seq;
			endcase
		end
	end

	//--------------------------------------------------------------
	// Transmit DLLP fault
	//--------------------------------------------------------------
	// Transmit field orders its classes differently from the receive one
	always_comb begin
		case (tx_field)
			2'h1:    tx_class_sel = PFI_DLLP_PM;
			2'h2:    tx_class_sel = PFI_DLLP_FC;
			2'h3:    tx_class_sel = PFI_DLLP_ACKNAK;
			default: tx_class_sel = 2'h0;
		endcase
	end

	assign tx_hit = tx_dllp_valid && (tx_field != 2'h0) && (tx_dllp_class == tx_class_sel);

	always_ff @(posedge mclk) begin
		if (srst) begin
			tx_dllp_crc_corrupt <= 1'b0;
		end else if (ce) begin
			tx_dllp_crc_corrupt <= tx_hit;
		end
	end

	//--------------------------------------------------------------
	// Credit update fault and debug channel select
	//--------------------------------------------------------------
	pfi_credit_adj u_credit (
		.mclk          (mclk),
		.srst          (srst),
		.ce            (ce),
		.fault_code    (ctrl[PFI_UFC_LSB +: 5]),
		.ufc_valid     (ufc_valid),
		.ufc_type      (ufc_type),
		.ufc_hdr       (ufc_hdr),
		.ufc_data      (ufc_data),
		.ufc_out_valid (ufc_out_valid),
		.ufc_out_hdr   (ufc_out_hdr),
		.ufc_out_data  (ufc_out_data),
		.ufc_hit       (ufc_hit)
	);

	// Selects above the built channels show zero; the driver keeps them low
	pfi_vc_mux #(
		.NUM_VC (NUM_VC)
	) u_vc_mux (
		.mclk      (mclk),
		.srst      (srst),
		.ce        (ce),
		.vc_sel    (ctrl[PFI_VCSEL_LSB +: 3]),
		.vc_debug  (vc_debug),
		.dbg_slice (dbg_slice)
	);

	//--------------------------------------------------------------
	// Injection status
	//--------------------------------------------------------------
	// Order: rx DLLP, ACK, tx DLLP, credit, replay
	assign hit_vec = {force_replay, ufc_hit, tx_dllp_crc_corrupt, ack_out_nak, rx_dllp_crc_force};

	// Write one to clear; a new injection in the same cycle wins
	always_comb begin
		next_sticky = sticky;
		if (wr_en && sel_status) begin
			next_sticky = sticky & ~pwdata[4:0];
		end
		next_sticky = next_sticky | hit_vec;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			sticky <= PFI_STICKY_RESET;
		end else if (ce) begin
			sticky <= next_sticky;
		end
	end

	// Counts cycles with an rx DLLP, ACK, tx DLLP or credit injection (not replay), saturating; a write to the count register clears it
	always_ff @(posedge mclk) begin
		if (srst) begin
			inject_count <= PFI_COUNT_RESET;
		end else if (ce) begin
			if (wr_en && sel_count) begin
				inject_count <= PFI_COUNT_RESET;
			end else if ((|hit_vec[3:0]) && (inject_count != 16'hFFFF)) begin
				inject_count <= inject_count + 16'h0001;
			end
		end
	end
endmodule : pfi_ctrl

`default_nettype wire

// >>> pfi_ctrl_bench.sv
// Testbench for pfi_ctrl: APB access, then each fault kind in turn.
// Assumes pfi_pkg, the design, the link model and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module pfi_ctrl_bench import pfi_pkg::*; ;
	logic        mclk = 1'b0, srst = 1'b1, ce = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd, e;
	logic        pready, pslverr, err, rx_dllp_valid, rx_dllp_crc_force, force_replay;
	logic        ack_in_valid, ack_out_valid, ack_out_nak, tx_ecrc_corrupt, tx_lcrc_corrupt;
	logic        tx_dllp_valid, tx_dllp_crc_corrupt, ufc_valid, ufc_out_valid;
	logic [1:0]  rx_dllp_class, tx_dllp_class, ufc_type;
	logic [PFI_SEQ_W-1:0]       ack_in_seq, ack_out_seq;
	logic [PFI_HDR_W-1:0]       ufc_hdr, ufc_out_hdr;
	logic [PFI_DATA_W-1:0]      ufc_data, ufc_out_data;
	logic [3*PFI_DBG_SLICE-1:0] vc_debug;
	logic [PFI_DBG_SLICE-1:0]   dbg_slice;
	int          num_errors = 0, checked = 0;
	int          lvl_bit[4] = '{PFI_REPLAY_BIT, PFI_ECRC_BIT, PFI_LCRC_BIT, 0};
	logic [2:0]  lvl_exp[4] = '{3'h4, 3'h2, 3'h1, 3'h0};
	logic [11:0] seq_exp[4] = '{12'h000, 12'h000, 12'h001, 12'hFFF};
	logic [4:0]  vc_pat[4] = '{5'h05, 5'h0A, 5'h13, 5'h00};
	// Credit code, matching type, header step, data step
	int          ufc_tab[8][4] = '{'{0, 0, 0, 0}, '{1, 1, 1, 0}, '{2, 1, 0, 1}, '{3, 1, 1, 1},
		'{4, 2, 1, 0}, '{12, 1, -1, -1}, '{16, 3, -1, 0}, '{17, 3, 0, -1}};

	always #10 mclk = ~mclk;
	pfi_ctrl #(.IS_X8(1'b0), .NUM_VC(3)) i_dut (.*);
	pfi_link_model i_link (.*);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// No wait count is assumed; the watchdog ends a stuck slave
		forever begin
			@(posedge mclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic end_of_test();
		$display("errors %0d, checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test

	initial begin : watchdog
		#(5000 * 20);
		num_errors++;
		end_of_test();
	end

	initial begin : main
		int i;
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		apb(1'b0, PFI_CTRL_OFFSET, 32'h0);
		chk(rd, PFI_CTRL_RESET);
		apb(1'b0, 12'h0FC, 32'h0);
		chk({err, rd[30:0]}, 32'h8000_0000);
		apb(1'b1, PFI_CTRL_OFFSET, 32'hFFFF_FFFF);
		apb(1'b0, PFI_CTRL_OFFSET, 32'h0);
		chk(rd, PFI_CTRL_MASK);
		foreach (lvl_bit[j]) begin
			apb(1'b1, PFI_CTRL_OFFSET, 32'h1 << lvl_bit[j]);
			@(posedge mclk);
			#1;
			chk({force_replay, tx_ecrc_corrupt, tx_lcrc_corrupt}, lvl_exp[j]);
		end
		for (i = 1; i < 4; i++) begin
			apb(1'b1, PFI_CTRL_OFFSET, i << PFI_RXDLLP_LSB);
			i_link.ev(0, 2'(i % 3 + 1), 20'h00000);
			#1;
			chk(rx_dllp_crc_force, 1'b0);
			for (int n = 0; n < 2; n++) begin
				i_link.ev(0, i[1:0], 20'h00000);
				#1;
				chk(rx_dllp_crc_force, n == 0);
			end
			for (int c = 1; c < 4; c++) begin
				i_link.ev(2, c[1:0], 20'h00000);
				#1;
				chk(tx_dllp_crc_corrupt, 1'b0);
			end
		end
		for (i = 1; i < 4; i++) begin
			apb(1'b1, PFI_CTRL_OFFSET, i << PFI_TXDLLP_LSB);
			for (int c = 1; c < 4; c++) begin
				i_link.ev(2, c[1:0], 20'h00000);
				#1;
				chk(tx_dllp_crc_corrupt, c == i % 3 + 1);
			end
		end
		apb(1'b1, PFI_COUNT_OFFSET, 32'h0);
		for (i = 0; i < 4; i++) begin
			apb(1'b1, PFI_CTRL_OFFSET, i << PFI_ACKNAK_LSB);
			i_link.ev(1, 2'h0, 20'h00000);
			#1;
			chk({ack_out_valid, ack_out_nak, ack_out_seq}, {1'b1, i != 0, seq_exp[i]});
		end
		apb(1'b0, PFI_COUNT_OFFSET, 32'h0);
		chk(rd, 32'h3);
		foreach (ufc_tab[k]) begin
			apb(1'b1, PFI_CTRL_OFFSET, ufc_tab[k][0] << PFI_UFC_LSB);
			for (int t = 0; t < 4; t++) begin
				i = (t == ufc_tab[k][1]);
				e = {12'h001, 8'(8'hFF + i * ufc_tab[k][2]), 12'(i * ufc_tab[k][3])};
				i_link.ev(3, t[1:0], 20'hFF000);
				#1;
				chk({ufc_out_valid, ufc_out_hdr, ufc_out_data}, e);
			end
		end
		for (i = 0; i < 4; i++) begin
			apb(1'b1, PFI_CTRL_OFFSET, i << PFI_VCSEL_LSB);
			@(posedge mclk);
			#1;
			chk(dbg_slice === {25{vc_pat[i]}}, 1'b1);
		end
		apb(1'b0, PFI_STATUS_OFFSET, 32'h0);
		chk(rd, 32'h1F);
		apb(1'b1, PFI_STATUS_OFFSET, 32'h1F);
		apb(1'b0, PFI_STATUS_OFFSET, 32'h0);
		chk(rd, 32'h0);
		// Clock enable low stalls the slave; the write must wait for it
		@(posedge mclk);
		ce <= 1'b0;
		fork
			begin
				repeat (4) @(posedge mclk);
				ce <= 1'b1;
			end
			apb(1'b1, PFI_CTRL_OFFSET, 32'h0);
		join
		apb(1'b0, PFI_CTRL_OFFSET, 32'h0);
		chk(rd, 32'h0);
		end_of_test();
	end
endmodule : pfi_ctrl_bench
`default_nettype wire

// >>> pfi_ctrl_monitor.sv
// Checker for pfi_ctrl: each injected fault is tied to the event or write behind it.
// Assumes it is bound to pfi_ctrl and sees nothing but its ports.
`timescale 1ns/10ps
`default_nettype none
//------------------------------------------------------------
// Checker
//------------------------------------------------------------
module pfi_ctrl_monitor import pfi_pkg::*; (
	input wire logic                  mclk,
	input wire logic                  srst,
	input wire logic                  ce,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [11:0]           paddr,
	input wire logic                  rx_dllp_valid,
	input wire logic                  rx_dllp_crc_force,
	input wire logic                  force_replay,
	input wire logic                  ack_in_valid,
	input wire logic [PFI_SEQ_W-1:0]  ack_in_seq,
	input wire logic                  ack_out_valid,
	input wire logic                  ack_out_nak,
	input wire logic [PFI_SEQ_W-1:0]  ack_out_seq,
	input wire logic                  tx_ecrc_corrupt,
	input wire logic                  tx_lcrc_corrupt,
	input wire logic                  tx_dllp_valid,
	input wire logic                  tx_dllp_crc_corrupt,
	input wire logic                  ufc_valid,
	input wire logic [1:0]            ufc_type,
	input wire logic [PFI_HDR_W-1:0]  ufc_hdr,
	input wire logic [PFI_DATA_W-1:0] ufc_data,
	input wire logic                  ufc_out_valid,
	input wire logic [PFI_HDR_W-1:0]  ufc_out_hdr,
	input wire logic [PFI_DATA_W-1:0] ufc_out_data
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	// A frozen clock enable holds pulses, so the cause is looked for only after a live edge
	property p_rx_force; rx_dllp_crc_force && $past(ce) |-> $past(rx_dllp_valid); endproperty
	a_rx_force: assert property (p_rx_force) else $error("rx force with no dllp");
	property p_ack_pass; ack_in_valid && ce |=> ack_out_valid; endproperty
	a_ack_pass: assert property (p_ack_pass) else $error("ack not passed on");
	property p_ack_seq;
		ack_out_valid && $past(ce) |-> (ack_out_nak ? (12'(ack_out_seq - $past(ack_in_seq))
			inside {12'h000, 12'h001, 12'hFFF}) : (ack_out_seq == $past(ack_in_seq)));
	endproperty
	a_ack_seq: assert property (p_ack_seq) else $error("ack sequence off");
	property p_tx_dllp; tx_dllp_crc_corrupt && $past(ce) |-> $past(tx_dllp_valid); endproperty
	a_tx_dllp: assert property (p_tx_dllp) else $error("tx corrupt with no dllp");
	property p_ufc_pass; ufc_valid && ce |=> ufc_out_valid; endproperty
	a_ufc_pass: assert property (p_ufc_pass) else $error("credit update lost");
	property p_ufc_step;
		ufc_out_valid && $past(ce) |-> (8'(ufc_out_hdr - $past(ufc_hdr)) inside {8'h00, 8'h01,
			8'hFF}) && (12'(ufc_out_data - $past(ufc_data)) inside {12'h000, 12'h001, 12'hFFF});
	endproperty
	a_ufc_step: assert property (p_ufc_step) else $error("credit moved by more than one");
	property p_ufc_none;
		ufc_out_valid && $past(ce) && $past(ufc_type) == PFI_UFC_NONE
			|-> ufc_out_hdr == $past(ufc_hdr) && ufc_out_data == $past(ufc_data);
	endproperty
	a_ufc_none: assert property (p_ufc_none) else $error("untyped update altered");
	property p_levels;
		$changed({force_replay, tx_ecrc_corrupt, tx_lcrc_corrupt})
			|-> $past(psel && penable && pwrite && paddr == PFI_CTRL_OFFSET, 2);
	endproperty
	a_levels: assert property (p_levels) else $error("fault level moved alone");
endmodule : pfi_ctrl_monitor

bind pfi_ctrl pfi_ctrl_monitor i_mon (.mclk(mclk), .srst(srst), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .rx_dllp_valid(rx_dllp_valid),
	.rx_dllp_crc_force(rx_dllp_crc_force), .force_replay(force_replay),
	.ack_in_valid(ack_in_valid), .ack_in_seq(ack_in_seq), .ack_out_valid(ack_out_valid),
	.ack_out_nak(ack_out_nak), .ack_out_seq(ack_out_seq), .tx_ecrc_corrupt(tx_ecrc_corrupt),
	.tx_lcrc_corrupt(tx_lcrc_corrupt), .tx_dllp_valid(tx_dllp_valid),
	.tx_dllp_crc_corrupt(tx_dllp_crc_corrupt), .ufc_valid(ufc_valid), .ufc_type(ufc_type),
	.ufc_hdr(ufc_hdr), .ufc_data(ufc_data), .ufc_out_valid(ufc_out_valid),
	.ufc_out_hdr(ufc_out_hdr), .ufc_out_data(ufc_out_data));
`default_nettype wire

// >>> pfi_link_model.sv
// Stand-in for the link layer and the channel debug buses feeding pfi_ctrl.
// Assumes three channels are built and the bench calls ev() for each event.
`timescale 1ns/10ps
`default_nettype none
module pfi_link_model import pfi_pkg::*; (
	input  wire logic                       mclk,
	output var  logic                       rx_dllp_valid,
	output var  logic [1:0]                 rx_dllp_class,
	output var  logic                       ack_in_valid,
	output var  logic [PFI_SEQ_W-1:0]       ack_in_seq,
	output var  logic                       tx_dllp_valid,
	output var  logic [1:0]                 tx_dllp_class,
	output var  logic                       ufc_valid,
	output var  logic [1:0]                 ufc_type,
	output var  logic [PFI_HDR_W-1:0]       ufc_hdr,
	output var  logic [PFI_DATA_W-1:0]      ufc_data,
	output wire logic [3*PFI_DBG_SLICE-1:0] vc_debug
);
	// Distinct pattern per channel, channel 0 lowest
	assign vc_debug = {{25{5'h13}}, {25{5'h0A}}, {25{5'h05}}};
	initial begin
		{rx_dllp_valid, ack_in_valid, tx_dllp_valid, ufc_valid} = 4'h0;
		{rx_dllp_class, tx_dllp_class, ufc_type} = 6'h00;
		ack_in_seq = 12'h000;
		{ufc_hdr, ufc_data} = 20'h00000;
	end
	// Kind 0 rx dllp, 1 ack, 2 tx dllp, 3 credit update; one-cycle strobe
	task automatic ev(input int k, input logic [1:0] c, input logic [19:0] d);
		@(posedge mclk);
		rx_dllp_valid <= (k == 0);
		ack_in_valid <= (k == 1);
		tx_dllp_valid <= (k == 2);
		ufc_valid <= (k == 3);
		{rx_dllp_class, tx_dllp_class, ufc_type} <= {c, c, c};
		ack_in_seq <= d[11:0];
		{ufc_hdr, ufc_data} <= d;
		@(posedge mclk);
		// Qualifiers flip once the strobe drops, so a stale value never looks valid
		{rx_dllp_valid, ack_in_valid, tx_dllp_valid, ufc_valid} <= 4'h0;
		{rx_dllp_class, tx_dllp_class, ufc_type} <= ~{c, c, c};
		ack_in_seq <= ~d[11:0];
		{ufc_hdr, ufc_data} <= ~d;
	endtask : ev
endmodule : pfi_link_model
`default_nettype wire

// >>> pfi_vc_mux.sv
// Virtual-channel selector for the upper debug-output slice.
// Assumes each channel's debug slice arrives packed, channel 0 lowest.

`timescale 1ns/10ps
`default_nettype none

module pfi_vc_mux import pfi_pkg::*; #(
	parameter int NUM_VC = 4
) (
	input  wire logic                            mclk,
	input  wire logic                            srst,
	input  wire logic                            ce,
	input  wire logic [2:0]                      vc_sel,
	input  wire logic [NUM_VC*PFI_DBG_SLICE-1:0] vc_debug,
	output logic [PFI_DBG_SLICE-1:0]             dbg_slice
);
	logic [PFI_DBG_SLICE-1:0] next_dbg_slice;

	// Unbuilt channels show zero rather than aliasing a real one
	always_comb begin
		next_dbg_slice = '0;
		for (int i = 0; i < NUM_VC; i++) begin
			if (vc_sel == i[2:0]) begin
				next_dbg_slice = vc_debug[i*PFI_DBG_SLICE +: PFI_DBG_SLICE];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			dbg_slice <= '0;
		end else if (ce) begin
			dbg_slice <= next_dbg_slice;
		end
	end
endmodule : pfi_vc_mux

`default_nettype wire
